// ---- hw/anar_pend.v ----
// anar_pend.v: deferred-update advertisement bits (written vs in use).
// assumes: upd_i is a one-cycle pulse from the owning block's clock.
`include "anar_map.vh"

module anar_pend (
    input  wire       clk_i,    // block clock
    input  wire       rst_n_i,  // async reset, active low
    input  wire       wr_i,     // software write strobe
    input  wire [1:0] wr_val_i, // written value {fd, hd}
    input  wire       upd_i,    // update event pulse
    output wire [1:0] held_o,   // value software last wrote
    output wire [1:0] eff_o     // value in use on the link
);

    // reset pattern split per lane, so each lane takes its own bit
    localparam [1:0] adv_rst = `ANAR_ADV10_RST;

    // ------------------------------------------------------------
    // one generate lane per advertisement bit
    // ------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : g_lane
            reg held_r;
            reg eff_r;
            // held copy follows every write at once
            always @(posedge clk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    held_r <= adv_rst[g];
                end else if (wr_i) begin
                    held_r <= wr_val_i[g];
                end
            end
            // deferred until update
            // a write in the same cycle as the update is not lost
            always @(posedge clk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    eff_r <= adv_rst[g];
                end else if (upd_i) begin
                    eff_r <= wr_i ? wr_val_i[g] : held_r;
                end
            end
            assign held_o[g] = held_r;
            assign eff_o[g]  = eff_r;
        end
    endgenerate

endmodule

// ---- hw/anar_sync.v ----
// anar_sync.v: two-stage synchroniser for levels arriving from pins.
// assumes: inputs are asynchronous levels; one flop stage-1 per bit.
`include "anar_map.vh"

module anar_sync #(
    parameter W = 1
) (
    input  wire         clk_i,    // block clock
    input  wire         rst_n_i,  // async reset, active low
    input  wire [W-1:0] d_i,      // asynchronous level
    output wire [W-1:0] q_o       // synchronised level
);

    // ------------------------------------------------------------
    // two flops per bit; stage one is read only by stage two
    // ------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < W; g = g + 1) begin : g_bit
            reg meta_r;
            reg sync_r;
            always @(posedge clk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    meta_r <= 1'b0;
                    sync_r <= 1'b0;
                end else begin
                    meta_r <= d_i[g];
                    sync_r <= meta_r;
                end
            end
            assign q_o[g] = sync_r;
        end
    endgenerate

endmodule

// ---- hw/anar_top.v ----
// anar_top.v: auto-negotiation ability registers behind an APB slave.
// assumes: the negotiation engine shares MCLK_I and gives each accepted
// base page as a word with a one-cycle valid; LINK_UP_I is a pin.
`include "anar_map.vh"

module anar_top (
    input  wire        MCLK_I,         // block clock, 20 MHz
    input  wire        RST_N_I,        // async hardware reset, low
    input  wire        PSEL_I,         // apb select
    input  wire        PENABLE_I,      // apb enable
    input  wire        PWRITE_I,       // apb direction, high = write
    input  wire [7:0]  PADDR_I,        // apb byte address
    input  wire [31:0] PWDATA_I,       // apb write data
    output wire [31:0] PRDATA_O,       // apb read data
    output wire        PREADY_O,       // apb ready
    output wire        PSLVERR_O,      // apb error, unmapped address
    input  wire        LINK_UP_I,      // copper link status pin
    input  wire [15:0] RX_CW_I,        // received base-page code word
    input  wire        RX_CW_VALID_I,  // base page accepted, pulse
    output wire        ADV_10FD_O,     // advertise 10BASE-T full
    output wire        ADV_10HD_O,     // advertise 10BASE-T half
    output wire [4:0]  ADV_SEL_O,      // advertised selector
    output wire        ADV_1000FD_O,   // advertise 1000BASE-T full
    output wire        ADV_1000HD_O,   // advertise 1000BASE-T half
    output wire        AN_EN_O,        // negotiation running
    output wire        AN_RESTART_O    // restart negotiation, pulse
);

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    reg  [15:0] ctl_r;
    reg  [15:0] lpa_r;
    reg         lp_valid_r;
    reg  [4:0]  sel_r;
    reg  [1:0]  gig_r;
    reg         aux_pdn_r;
    reg         swrst_p_r;
    reg         restart_p_r;
    reg         pdn_q_r;
    reg         link_q_r;
    reg         upd_r;
    reg  [31:0] prdata_r;
    reg         pready_r;
    reg         pslverr_r;
    reg         adv_10fd_r;
    reg         adv_10hd_r;
    reg  [4:0]  adv_sel_r;
    reg         adv_1000fd_r;
    reg         adv_1000hd_r;
    reg         an_en_r;
    reg         an_restart_r;
    reg  [31:0] rd_nxt;
    reg         hit_nxt;

    wire        link_s;
    wire [1:0]  adv_held;
    wire [1:0]  adv_eff;
    wire [4:0]  idx;
    wire        setup;
    wire        wr_acc;
    wire        wr_ctl;
    wire        wr_adv;
    wire        wr_gig;
    wire        wr_aux;
    wire        pdn;
    wire        forced_1000;
    wire        upd_evt;

    // ------------------------------------------------------------
    // pin synchroniser and bus decode
    // ------------------------------------------------------------
    anar_sync #(
        .W (1)
    ) u_link_sync (
        .clk_i   (MCLK_I),
        .rst_n_i (RST_N_I),
        .d_i     (LINK_UP_I),
        .q_o     (link_s)
    );

    assign idx    = PADDR_I[6:2];
    assign setup  = PSEL_I & ~PENABLE_I;
    // write lands at the access edge where ready is seen high
    assign wr_acc = PSEL_I & PENABLE_I & PWRITE_I & pready_r & ~pslverr_r;
    assign wr_ctl = wr_acc & (idx == `ANAR_IDX_CTRL);
    assign wr_adv = wr_acc & (idx == `ANAR_IDX_ADV);
    assign wr_gig = wr_acc & (idx == `ANAR_IDX_GIG);
    assign wr_aux = wr_acc & (idx == `ANAR_IDX_AUX);

    // ------------------------------------------------------------
    // control register with self-clearing command bits
    // ------------------------------------------------------------
    // soft reset and restart are strobes, so they always read zero
    always @(posedge MCLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            ctl_r       <= `ANAR_CTL_RST;
            swrst_p_r   <= 1'b0;
            restart_p_r <= 1'b0;
        end else begin
            if (wr_ctl) begin
                ctl_r <= PWDATA_I[15:0] & `ANAR_CTL_WMASK;
            end
            swrst_p_r   <= wr_ctl & PWDATA_I[`ANAR_CTL_SWRST];
            restart_p_r <= wr_ctl & PWDATA_I[`ANAR_CTL_RESTART];
        end
    end

    // second power-down control and gigabit advertisement
    always @(posedge MCLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            aux_pdn_r <= 1'b0;
            gig_r     <= `ANAR_GIG_RST;
        end else begin
            if (wr_aux) begin
                aux_pdn_r <= PWDATA_I[`ANAR_AUX_PDN];
            end
            if (wr_gig) begin
                gig_r <= PWDATA_I[`ANAR_GIG_FD:`ANAR_GIG_HD];
            end
        end
    end

    // ------------------------------------------------------------
    // update events for the pending advertisement
    // ------------------------------------------------------------
    assign pdn = ctl_r[`ANAR_CTL_PDN] | aux_pdn_r;

    // edge history for power-down exit and link loss
    always @(posedge MCLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            pdn_q_r  <= 1'b0;
            link_q_r <= 1'b0;
        end else begin
            pdn_q_r  <= pdn;
            link_q_r <= link_s;
        end
    end

    assign upd_evt = swrst_p_r | restart_p_r | (pdn_q_r & ~pdn) |
                     (link_q_r & ~link_s);

    always @(posedge MCLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            upd_r <= 1'b0;
        end else begin
            upd_r <= upd_evt;
        end
    end

    anar_pend u_adv10 (
        .clk_i    (MCLK_I),
        .rst_n_i  (RST_N_I),
        .wr_i     (wr_adv),
        .wr_val_i (PWDATA_I[`ANAR_ADV_10FD:`ANAR_ADV_10HD]),
        .upd_i    (upd_evt),
        .held_o   (adv_held),
        .eff_o    (adv_eff)
    );

    always @(posedge MCLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            sel_r <= `ANAR_SEL_RST;
        end else if (wr_adv) begin
            sel_r <= PWDATA_I[`ANAR_ADV_SEL_HI:`ANAR_ADV_SEL_LO];
        end
    end

    // ------------------------------------------------------------
    // link partner ability register
    // ------------------------------------------------------------
    // whole word loads at once
    // bits kept in received order so every field lands at its own position;
    // a soft reset in the same cycle as a page wins, since the page belongs
    // to the negotiation being torn down; a page beats a link loss in the same cycle
    always @(posedge MCLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            lpa_r      <= `ANAR_LPA_RST;
            lp_valid_r <= 1'b0;
        end else if (swrst_p_r) begin
            lpa_r      <= `ANAR_LPA_RST;
            lp_valid_r <= 1'b0;
        end else if (RX_CW_VALID_I) begin
            lpa_r      <= RX_CW_I;
            lp_valid_r <= 1'b1;
        end else if (link_q_r & ~link_s) begin
            lp_valid_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // advertisement actually offered on the link
    // ------------------------------------------------------------
    // forced 1000 still negotiates
    assign forced_1000 = ~ctl_r[`ANAR_CTL_ANEN] & ctl_r[`ANAR_CTL_SPD_MSB] &
                         ~ctl_r[`ANAR_CTL_SPD_LSB];

    // outputs registered so the link side sees glitch-free levels
    always @(posedge MCLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            adv_10fd_r   <= 1'b0;
            adv_10hd_r   <= 1'b0;
            adv_sel_r    <= `ANAR_SEL_RST;
            adv_1000fd_r <= 1'b0;
            adv_1000hd_r <= 1'b0;
            an_en_r      <= 1'b0;
            an_restart_r <= 1'b0;
        end else begin
            adv_sel_r    <= sel_r;
            an_en_r      <= ctl_r[`ANAR_CTL_ANEN] | forced_1000;
            an_restart_r <= upd_r;
            if (forced_1000) begin
                adv_10fd_r   <= 1'b0;
                adv_10hd_r   <= 1'b0;
                adv_1000fd_r <= ctl_r[`ANAR_CTL_DUPLEX];
                adv_1000hd_r <= ~ctl_r[`ANAR_CTL_DUPLEX];
            end else begin
                adv_10fd_r   <= adv_eff[1];
                adv_10hd_r   <= adv_eff[0];
                adv_1000fd_r <= gig_r[1];
                adv_1000hd_r <= gig_r[0];
            end
        end
    end

    // ------------------------------------------------------------
    // read mux, evaluated from the setup-phase address
    // ------------------------------------------------------------
    always @* begin
        rd_nxt  = 32'h00000000;
        hit_nxt = (PADDR_I[1:0] == 2'h0) & ~PADDR_I[7];
        case (idx)
            `ANAR_IDX_CTRL: begin
                rd_nxt[15:0] = ctl_r;
            end
            `ANAR_IDX_STAT: begin
                rd_nxt[`ANAR_STAT_LINK]    = link_s;
                rd_nxt[`ANAR_STAT_LPVALID] = lp_valid_r;
                rd_nxt[`ANAR_STAT_FORCED]  = forced_1000;
            end
            `ANAR_IDX_ADV: begin
                rd_nxt[`ANAR_ADV_10FD:`ANAR_ADV_10HD]     = adv_held;
                rd_nxt[`ANAR_ADV_SEL_HI:`ANAR_ADV_SEL_LO] = sel_r;
            end
            `ANAR_IDX_LPA: begin
                rd_nxt[15:0] = lpa_r;
            end
            `ANAR_IDX_GIG: begin
                rd_nxt[`ANAR_GIG_FD:`ANAR_GIG_HD] = gig_r;
            end
            `ANAR_IDX_AUX: begin
                rd_nxt[`ANAR_AUX_PDN] = aux_pdn_r;
            end
            default: begin
                hit_nxt = 1'b0;
            end
        endcase
    end

    // ------------------------------------------------------------
    // apb answer: ready one edge after setup, so no wait states
    // ------------------------------------------------------------
    // a write to the read-only partner word is accepted and dropped
    always @(posedge MCLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            prdata_r  <= 32'h00000000;
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
        end else if (setup) begin
            prdata_r  <= PWRITE_I ? 32'h00000000 : rd_nxt;
            pready_r  <= 1'b1;
            pslverr_r <= ~hit_nxt;
        end else begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign PRDATA_O     = prdata_r;
    assign PREADY_O     = pready_r;
    assign PSLVERR_O    = pslverr_r;
    assign ADV_10FD_O   = adv_10fd_r;
    assign ADV_10HD_O   = adv_10hd_r;
    assign ADV_SEL_O    = adv_sel_r;
    assign ADV_1000FD_O = adv_1000fd_r;
    assign ADV_1000HD_O = adv_1000hd_r;
    assign AN_EN_O      = an_en_r;
    assign AN_RESTART_O = an_restart_r;

endmodule

// ---- shared/anar_map.vh ----
// anar_map.vh: register indices, field positions and reset values of
// the auto-negotiation ability register block.
// assumes: included by bare name from the design files under hw/.
`ifndef ANAR_MAP_VH
`define ANAR_MAP_VH

// ----------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define ANAR_IDX_CTRL      5'h00
`define ANAR_IDX_STAT      5'h01
`define ANAR_IDX_ADV       5'h04
`define ANAR_IDX_LPA       5'h05
`define ANAR_IDX_GIG       5'h09
`define ANAR_IDX_AUX       5'h10

// ----------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------
`define ANAR_CTL_SWRST     15
`define ANAR_CTL_SPD_LSB   13
`define ANAR_CTL_ANEN      12
`define ANAR_CTL_PDN       11
`define ANAR_CTL_RESTART   9
`define ANAR_CTL_DUPLEX    8
`define ANAR_CTL_SPD_MSB   6
`define ANAR_CTL_RST       16'h1140
`define ANAR_CTL_WMASK     16'h3940

// ----------------------------------------------------------------
// advertisement, gigabit control, aux and status fields
// ----------------------------------------------------------------
`define ANAR_ADV_10FD      6
`define ANAR_ADV_10HD      5
`define ANAR_ADV_SEL_HI    4
`define ANAR_ADV_SEL_LO    0
`define ANAR_ADV10_RST     2'h3
`define ANAR_SEL_RST       5'h01
`define ANAR_GIG_FD        9
`define ANAR_GIG_HD        8
`define ANAR_GIG_RST       2'h3
`define ANAR_AUX_PDN       2
`define ANAR_STAT_LINK     2
`define ANAR_STAT_LPVALID  1
`define ANAR_STAT_FORCED   0
`define ANAR_LPA_RST       16'h0000

`endif

// ---- sim/anar_lp_model.sv ----
// anar_lp_model.sv: behavioural link partner handing over accepted pages.
// assumes: shares the block clock; pages arrive already accepted.
module anar_lp_model (
    input  logic        clk_i,   // block clock
    output logic [15:0] cw_o,    // base-page code word
    output logic        valid_o, // page accepted, one cycle
    output logic        link_o   // copper link level
);
    timeunit 1ns;
    timeprecision 1ns;
    // link up from the start so reset release is no link loss
    initial begin
        cw_o = 16'h5A5A;
        valid_o = 1'b0;
        link_o = 1'b1;
    end
    // one page per call; the word is only meaningful with valid
    task automatic send_page(input logic [15:0] w);
        @(posedge clk_i);
        cw_o <= w;
        valid_o <= 1'b1;
        @(posedge clk_i);
        valid_o <= 1'b0;
        // released word shows its inverse so stale data never matches
        cw_o <= ~w;
    endtask
    // link level change, taken after an edge
    task automatic set_link(input logic v);
        @(posedge clk_i);
        link_o <= v;
    endtask
endmodule

// ---- sim/anar_top_assertions.sv ----
// anar_top_assertions.sv: port-level checker for the ability registers.
// assumes: bound to anar_top; zero-wait APB slave, byte addr = 4 * index.
module anar_top_chk (
    input logic        MCLK_I,        // clock
    input logic        RST_N_I,       // async reset, low
    input logic        PSEL_I,        // apb select
    input logic        PENABLE_I,     // apb enable
    input logic        PWRITE_I,      // apb direction
    input logic [7:0]  PADDR_I,       // apb address
    input logic [31:0] PWDATA_I,      // apb write data
    input logic [31:0] PRDATA_O,      // apb read data
    input logic        PREADY_O,      // apb ready
    input logic        PSLVERR_O,     // apb error
    input logic        LINK_UP_I,     // link pin
    input logic [15:0] RX_CW_I,       // received word
    input logic        RX_CW_VALID_I, // page accepted
    input logic        ADV_10FD_O,    // 10 full offered
    input logic        ADV_10HD_O,    // 10 half offered
    input logic [4:0]  ADV_SEL_O,     // selector offered
    input logic        AN_RESTART_O   // restart pulse
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge MCLK_I); endclocking
    default disable iff (!RST_N_I);
    logic        wr_acc;
    logic [15:0] lpa_r;
    logic [4:0]  sel_r;
    logic [3:0]  since_r;
    logic        link_r;
    assign wr_acc = PSEL_I && PENABLE_I && PREADY_O && PWRITE_I && !PSLVERR_O;
    // reference partner word, last selector, cycles since a legal update cause
    always @(posedge MCLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            lpa_r <= 16'h0000;
            sel_r <= 5'h01;
            since_r <= 4'h0;
            link_r <= 1'b1;
        end else begin
            link_r <= LINK_UP_I;
            if (RX_CW_VALID_I)
                lpa_r <= RX_CW_I;
            else if (wr_acc && PADDR_I == 8'h00 && PWDATA_I[15])
                lpa_r <= 16'h0000;
            if (wr_acc && PADDR_I == 8'h10)
                sel_r <= PWDATA_I[4:0];
            // ctrl/aux writes and link edges may move the advertisement
            if ((wr_acc && (PADDR_I == 8'h00 || PADDR_I == 8'h40)) || link_r != LINK_UP_I)
                since_r <= 4'h0;
            else if (since_r != 4'hF)
                since_r <= since_r + 4'h1;
        end
    end
    // ----
    // bus handshake
    // ----
    a_ready_setup:
        assert property (PSEL_I && !PENABLE_I |=> PREADY_O) else $error("no ready after setup");
    a_ready_single:
        assert property (PREADY_O |=> !PREADY_O) else $error("ready longer than one cycle");
    a_err_misalign:
        assert property (PSEL_I && !PENABLE_I && PADDR_I[1:0] != 2'h0 |=> PSLVERR_O && PREADY_O)
        else $error("misaligned access not refused");
    a_adv_mapped:
        assert property (PSEL_I && !PENABLE_I && PADDR_I == 8'h10 |=> !PSLVERR_O)
        else $error("advert access refused");
    a_upper_zero:
        assert property (PREADY_O && !PWRITE_I |-> PRDATA_O[31:16] == 16'h0000)
        else $error("upper read bits set");
    // ----
    // advertisement and partner word
    // ----
    a_restart_single:
        assert property ($rose(AN_RESTART_O) |=> !AN_RESTART_O) else $error("restart pulse too long");
    a_restart_follows:
        assert property (wr_acc && PADDR_I == 8'h00 && PWDATA_I[9] |-> ##[1:4] AN_RESTART_O)
        else $error("restart request lost");
    a_adv_deferred:
        assert property ($changed(ADV_10FD_O) || $changed(ADV_10HD_O) |-> since_r < 4'hA)
        else $error("advert moved without update event");
    a_sel_direct:
        assert property (wr_acc && PADDR_I == 8'h10 |-> ##[1:2] ADV_SEL_O == sel_r)
        else $error("selector not applied");
    a_lpa_mirror:
        assert property (PSEL_I && !PENABLE_I && !PWRITE_I && PADDR_I == 8'h14
                         |=> PRDATA_O == {16'h0000, lpa_r}) else $error("partner word differs");
endmodule

bind anar_top anar_top_chk anar_top_chk_inst (
    .MCLK_I(MCLK_I), .RST_N_I(RST_N_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I),
    .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I), .PRDATA_O(PRDATA_O),
    .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O), .LINK_UP_I(LINK_UP_I), .RX_CW_I(RX_CW_I),
    .RX_CW_VALID_I(RX_CW_VALID_I), .ADV_10FD_O(ADV_10FD_O), .ADV_10HD_O(ADV_10HD_O),
    .ADV_SEL_O(ADV_SEL_O), .AN_RESTART_O(AN_RESTART_O));

// ---- sim/autoneg_ability_regs_test.sv ----
// autoneg_ability_regs_test.sv: register-level tests of the ability block.
// assumes: anar_top, anar_lp_model and the bound checker are compiled.
module autoneg_ability_regs_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, err;
    logic        link, cw_vld, fd, hd, g_fd, g_hd, an_en, an_rst;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd, adv_v;
    logic [15:0] cw;
    logic [4:0]  sel;
    int          failures = 0;
    int          n_tests = 0;
    int          n_rst = 0;
    logic [15:0] pages [8] = '{16'h8000, 16'h4000, 16'h2000, 16'h1000,
                               16'h0C00, 16'h03E0, 16'h001F, 16'hA5A5};
    logic [7:0]  bad [3] = '{8'h08, 8'h11, 8'h80};
    // advertised state packed in register order for compact compares
    assign adv_v = {22'h0, g_fd, g_hd, an_en, fd, hd, sel};
    anar_top anar_top_inst (
        .MCLK_I(clk), .RST_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(penable),
        .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
        .PREADY_O(pready), .PSLVERR_O(pslverr), .LINK_UP_I(link), .RX_CW_I(cw),
        .RX_CW_VALID_I(cw_vld), .ADV_10FD_O(fd), .ADV_10HD_O(hd), .ADV_SEL_O(sel),
        .ADV_1000FD_O(g_fd), .ADV_1000HD_O(g_hd), .AN_EN_O(an_en), .AN_RESTART_O(an_rst));
    anar_lp_model anar_lp_model_inst (.clk_i(clk), .cw_o(cw), .valid_o(cw_vld), .link_o(link));
    // 20 MHz clock
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // count restart pulses seen on the port
    always @(posedge clk) if (an_rst === 1'b1) n_rst++;
    task final_report;
        if (failures == 0 && n_tests > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            $display("wrong value at %0t: got %h exp %h", $time, got, exp);
            failures++;
        end
    endtask
    // one apb transfer; request held until ready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        err = pslverr;
        if (n >= 50) failures++;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // hang guard, far beyond the few hundred cycles the tests need
    initial begin
        repeat (5000) @(posedge clk);
        failures++;
        final_report;
    end
    // ----
    // main sequence
    // ----
    initial begin
        {psel, penable, pwrite, rst_n} = 4'h0;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        wt(2);
        chk(adv_v, 32'h3E1);
        apb(0, 8'h10, 0);
        chk(rd, 32'h61);
        apb(0, 8'h14, 0);
        chk(rd, 32'h0);
        apb(1, 8'h10, 32'h21);
        wt(4);
        chk(adv_v, 32'h3E1);
        apb(0, 8'h10, 0);
        chk(rd, 32'h21);
        n_rst = 0;
        apb(1, 8'h00, 32'h1340);
        wt(6);
        chk(adv_v, 32'h3A1);
        chk(n_rst, 1);
        apb(1, 8'h10, 32'h61);
        apb(1, 8'h00, 32'h1940);
        wt(4);
        chk(adv_v, 32'h3A1);
        apb(1, 8'h00, 32'h1140);
        wt(6);
        chk(adv_v, 32'h3E1);
        apb(1, 8'h10, 32'h41);
        anar_lp_model_inst.set_link(1'b0);
        wt(8);
        chk(adv_v, 32'h3C1);
        anar_lp_model_inst.set_link(1'b1);
        // bits 15 to 12 alone, then the 0C00, 03E0 and 001F fields, then a mixed word
        for (int i = 0; i < 8; i++) begin
            anar_lp_model_inst.send_page(pages[i]);
            apb(0, 8'h14, 0);
            chk(rd, {16'h0, pages[i]});
        end
        // status: link up and partner page valid
        apb(0, 8'h04, 0);
        chk(rd, 32'h6);
        apb(1, 8'h14, 32'hFFFF);
        apb(0, 8'h14, 0);
        chk(rd, {16'h0, pages[7]});
        apb(1, 8'h10, 32'h62);
        apb(1, 8'h00, 32'h9140);
        wt(4);
        chk(adv_v, 32'h3E2);
        apb(0, 8'h00, 0);
        chk(rd, 32'h1140);
        apb(0, 8'h04, 0);
        chk(rd, 32'h4);
        apb(0, 8'h14, 0);
        chk(rd, 32'h0);
        apb(0, 8'h10, 0);
        chk(rd, 32'h62);
        apb(1, 8'h24, 32'h0);
        apb(1, 8'h00, 32'h0140);
        wt(4);
        chk(adv_v, 32'h282);
        apb(1, 8'h00, 32'h0040);
        wt(4);
        chk(adv_v, 32'h182);
        apb(0, 8'h04, 0);
        chk(rd, 32'h5);
        apb(1, 8'h00, 32'h1140);
        wt(4);
        chk(adv_v, 32'h0E2);
        apb(0, 8'h24, 0);
        chk(rd, 32'h0);
        // second power-down control: write held, applied on exit
        apb(1, 8'h40, 32'h4);
        apb(1, 8'h10, 32'h22);
        wt(4);
        chk(adv_v, 32'h0E2);
        apb(0, 8'h40, 0);
        chk(rd, 32'h4);
        apb(1, 8'h40, 32'h0);
        wt(6);
        chk(adv_v, 32'h0A2);
        foreach (bad[i]) begin
            apb(0, bad[i], 0);
            chk({31'h0, err}, 32'h1);
        end
        final_report;
    end
endmodule
